// File: include/motion_param_pkg.sv
//
// Contract
// [R01] Unit and machine values load at power-on
// [R02] Other groups commit at own validation points
// [R03] Reference offset commits on origin search done
// [R04] Workpiece offset commits on origin-set command
// [R05] Feed and ramp times commit at next operation
// [R06] Enabled axes one to variant max, default max
// [R07] Reset allocates every enabled axis to task 1
// [R08] Per-output choice: general or brake use; code holds outputs at or above the enabled axis count low in either use
// [R09] Brake outputs one to four follow X..U
// [R10] Outputs default to brake use
// [R11] Handwheel or encoder input, encoder ratio 1/2/4
// [R12] Default handwheel; ratio forced to one
// [R13] Pass time picks acceleration or deceleration
// [R14] Acceleration pass uses preceding accel time
// [R15] Deceleration pass uses preceding decel time
// [R16] Handwheel ratio and others apply on write
// [R17] Pending copy moves to active on event
//
package motion_param_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_UNIT_CFG = 8'h00;
  localparam logic [7:0] ADDR_TASK_CFG = 8'h04;
  localparam logic [7:0] ADDR_REF_OFS = 8'h08;
  localparam logic [7:0] ADDR_WRK_OFS = 8'h0c;
  localparam logic [7:0] ADDR_FEED = 8'h10;
  localparam logic [7:0] ADDR_ACCEL = 8'h14;
  localparam logic [7:0] ADDR_DECEL = 8'h18;
  localparam logic [7:0] ADDR_HW_RATIO = 8'h1c;
  localparam logic [7:0] ADDR_MISC = 8'h20;
  localparam logic [7:0] ADDR_ACT_REF = 8'h24;
  localparam logic [7:0] ADDR_ACT_WRK = 8'h28;
  localparam logic [7:0] ADDR_ACT_FEED = 8'h2c;
  localparam logic [7:0] ADDR_ACT_PASS = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;

  // ---------------------------------------------------------------
  // Unit config fields
  // ---------------------------------------------------------------
  localparam int UC_AXES_LSB = 0;
  localparam int UC_OUT_LSB = 4;
  localparam int UC_ENC_SEL = 8;
  localparam int UC_RATIO_LSB = 9;
  localparam int UC_PASS_DEC = 11;

  localparam logic [1:0] RATIO_1 = 2'h0;
  localparam logic [1:0] RATIO_2 = 2'h1;
  localparam logic [1:0] RATIO_4 = 2'h2;

  localparam logic [1:0] AXES_BITS = 2'h2;
  localparam logic [3:0] OUT_BRAKE_ALL = 4'h0;
  localparam logic [15:0] TASK1_ALL = 16'h000f;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] axes;
    logic [3:0] out_general;
    logic enc_sel;
    logic [1:0] enc_ratio;
    logic pass_decel;
    logic [15:0] task_map;
  } unit_cfg_s;

  typedef struct packed {
    logic origin_done;
    logic origin_set;
    logic motion_code;
    logic op_cmd;
    logic auto_mode;
  } event_s;

  typedef struct packed {
    logic [31:0] ref_ofs;
    logic [31:0] wrk_ofs;
    logic [31:0] feed;
    logic [31:0] accel;
    logic [31:0] decel;
  } param_set_s;

endpackage : motion_param_pkg

// File: hw/param_commit_slot.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Pending/active pair for one deferred parameter
// ---------------------------------------------------------------
module param_commit_slot #(
  parameter int W = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic commit,
  output logic [W-1:0] pend,
  output logic [W-1:0] act,
  output logic dirty
);
  import motion_param_pkg::*;

  typedef struct packed {
    logic [W-1:0] pend;
    logic [W-1:0] act;
    logic dirty;
  } slot_s;

  slot_s q, d;

  always_comb begin
    d = q;
    if (commit) begin
      d.act = q.pend; // R17
      d.dirty = 1'b0;
    end
    if (wr_en) begin
      d.pend = wr_data;
      d.dirty = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pend = q.pend;
  assign act = q.act;
  assign dirty = q.dirty;

  commit_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    commit |=> act == $past(pend)) // R17
    else $error("active copy did not take pending value");

endmodule : param_commit_slot

// File: hw/motion_param_commit.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// System parameter commit logic with AXI4-Lite slave
// ---------------------------------------------------------------
module motion_param_commit #(
  parameter logic [2:0] MAX_AXES = 3'h4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire motion_param_pkg::event_s events,
  input wire logic [15:0] handwheel_pulse_input,
  input wire logic [15:0] enc_count,
  input wire logic [3:0] brake_req,
  input wire logic [3:0] gp_out,
  output logic [3:0] dig_out,
  output motion_param_pkg::unit_cfg_s unit_active,
  output motion_param_pkg::param_set_s act_params,
  output logic [31:0] pass_time,
  output logic [17:0] follow_count,
  output logic [31:0] misc_cfg
);
  import motion_param_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    unit_cfg_s unit_pend;
    unit_cfg_s unit_act;
    logic [31:0] hw_ratio;
    logic [31:0] misc;
    logic [31:0] pass_time;
    logic [17:0] follow;
    logic [3:0] dig_out;
    logic boot;
    logic stored;
  } state_s;

  state_s q, d;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [2:0] clamp_axes(input logic [2:0] a);
    if (a == 3'h0 || a > MAX_AXES) begin
      return MAX_AXES; // R06
    end
    return a;
  endfunction : clamp_axes

  function automatic logic [15:0] axis_mask(input logic [2:0] a);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < a) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : axis_mask

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  logic wr_fire;
  logic [31:0] wr_val;
  logic [7:0] wr_addr;
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign wr_addr = q.aw_a;

  logic wr_ref, wr_wrk, wr_feed, wr_acc, wr_dec;
  assign wr_ref = wr_fire && wr_addr == ADDR_REF_OFS;
  assign wr_wrk = wr_fire && wr_addr == ADDR_WRK_OFS;
  assign wr_feed = wr_fire && wr_addr == ADDR_FEED;
  assign wr_acc = wr_fire && wr_addr == ADDR_ACCEL;
  assign wr_dec = wr_fire && wr_addr == ADDR_DECEL;

  // ---------------------------------------------------------------
  // Deferred parameter slots
  // ---------------------------------------------------------------
  logic op_evt;
  assign op_evt = events.auto_mode ? events.motion_code : events.op_cmd; // R05

  logic [31:0] p_ref, p_wrk, p_feed, p_acc, p_dec;
  logic [31:0] a_ref, a_wrk, a_feed, a_acc, a_dec;
  logic dy_ref, dy_wrk, dy_feed, dy_acc, dy_dec;

  param_commit_slot #(.W(32)) ref_slot (
    .ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_ref), .wr_data(wr_val),
    .commit(events.origin_done), // R02 R03
    .pend(p_ref), .act(a_ref), .dirty(dy_ref));
  param_commit_slot #(.W(32)) wrk_slot (
    .ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_wrk), .wr_data(wr_val),
    .commit(events.origin_set), // R04
    .pend(p_wrk), .act(a_wrk), .dirty(dy_wrk));
  param_commit_slot #(.W(32)) feed_slot (
    .ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_feed), .wr_data(wr_val),
    .commit(op_evt), // R05
    .pend(p_feed), .act(a_feed), .dirty(dy_feed));
  param_commit_slot #(.W(32)) acc_slot (
    .ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_acc), .wr_data(wr_val),
    .commit(op_evt), // R05
    .pend(p_acc), .act(a_acc), .dirty(dy_acc));
  param_commit_slot #(.W(32)) dec_slot (
    .ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_dec), .wr_data(wr_val),
    .commit(op_evt), // R05
    .pend(p_dec), .act(a_dec), .dirty(dy_dec));

  function automatic logic [31:0] wr_old(input logic [7:0] a);
    unique case (a)
      ADDR_REF_OFS: return p_ref;
      ADDR_WRK_OFS: return p_wrk;
      ADDR_FEED: return p_feed;
      ADDR_ACCEL: return p_acc;
      ADDR_DECEL: return p_dec;
      default: return ZERO32;
    endcase
  endfunction : wr_old

  always_comb wr_val = merge(wr_old(wr_addr), q.w_d, 4'hf);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  function automatic logic [32:0] rd_mux(input logic [7:0] a);
    unique case (a)
      ADDR_UNIT_CFG: return {1'b1, 20'h0_0000, q.unit_pend.pass_decel,
        q.unit_pend.enc_ratio, q.unit_pend.enc_sel,
        q.unit_pend.out_general, 1'b0, q.unit_pend.axes};
      ADDR_TASK_CFG: return {1'b1, 16'h0000, q.unit_pend.task_map};
      ADDR_REF_OFS: return {1'b1, p_ref};
      ADDR_WRK_OFS: return {1'b1, p_wrk};
      ADDR_FEED: return {1'b1, p_feed};
      ADDR_ACCEL: return {1'b1, p_acc};
      ADDR_DECEL: return {1'b1, p_dec};
      ADDR_HW_RATIO: return {1'b1, q.hw_ratio};
      ADDR_MISC: return {1'b1, q.misc};
      ADDR_ACT_REF: return {1'b1, a_ref};
      ADDR_ACT_WRK: return {1'b1, a_wrk};
      ADDR_ACT_FEED: return {1'b1, a_feed};
      ADDR_ACT_PASS: return {1'b1, q.pass_time};
      ADDR_STATUS: return {1'b1, 27'h000_0000, dy_dec, dy_acc, dy_feed,
        dy_wrk, dy_ref};
      default: return {1'b0, ZERO32};
    endcase
  endfunction : rd_mux

  logic [32:0] rd_res;
  // Mux reads state inside the function: needs always_comb sensitivity
  always_comb rd_res = rd_mux(araddr);

  logic [31:0] uc_merged;
  assign uc_merged = merge(ZERO32, q.w_d, 4'hf);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.boot = 1'b0;
    if (awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_a = awaddr;
    end
    if (wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.w_d = merge(ZERO32, wdata, wstrb);
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (wr_addr)
        ADDR_UNIT_CFG: begin
          // Held pending until power-on reload
          d.unit_pend.axes = clamp_axes(uc_merged[UC_AXES_LSB +: 3]); // R06
          d.unit_pend.out_general = uc_merged[UC_OUT_LSB +: 4]; // R08
          d.unit_pend.enc_sel = uc_merged[UC_ENC_SEL]; // R11
          d.unit_pend.enc_ratio = uc_merged[UC_RATIO_LSB +: 2];
          d.unit_pend.pass_decel = uc_merged[UC_PASS_DEC]; // R13
          d.stored = 1'b1;
        end
        ADDR_TASK_CFG: begin
          d.unit_pend.task_map = uc_merged[15:0];
          d.stored = 1'b1;
        end
        ADDR_HW_RATIO: d.hw_ratio = q.w_d; // R16
        ADDR_MISC: d.misc = q.w_d; // R16
        ADDR_REF_OFS, ADDR_WRK_OFS, ADDR_FEED, ADDR_ACCEL,
        ADDR_DECEL: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = rd_res[31:0];
      d.rresp = rd_res[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    // Unit values take effect only at power-on
    if (q.boot) begin
      d.unit_act = q.unit_pend; // R01
    end
    // Pass time from preceding operation's interpolation ramp
    if (op_evt) begin
      d.pass_time = q.unit_act.pass_decel ? a_dec : a_acc; // R13 R14 R15
    end
    unique case ({q.unit_act.enc_sel, q.unit_act.enc_ratio})
      {1'b1, RATIO_2}: d.follow = {1'b0, enc_count, 1'b0}; // R11
      {1'b1, RATIO_4}: d.follow = {enc_count, 2'b00};
      {1'b1, RATIO_1}: d.follow = {2'b00, enc_count};
      default: d.follow = q.unit_act.enc_sel ? {2'b00, enc_count}
                         : {2'b00, handwheel_pulse_input}; // R12
    endcase
    for (int i = 0; i < 4; i++) begin
      d.dig_out[i] = (3'(i) >= q.unit_act.axes) ? 1'b0 :
        q.unit_act.out_general[i] ? gp_out[i] : brake_req[i]; // R09
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.boot <= 1'b1;
      q.unit_act.axes <= MAX_AXES;
      q.unit_act.out_general <= OUT_BRAKE_ALL;
      q.unit_act.task_map <= TASK1_ALL & axis_mask(MAX_AXES);
      // Written unit values survive reset, as stored settings do
      if (q.stored) begin
        q.stored <= 1'b1;
        q.unit_pend <= q.unit_pend; // R01
      end else begin
        q.unit_pend.axes <= MAX_AXES; // R06
        q.unit_pend.out_general <= OUT_BRAKE_ALL; // R10
        q.unit_pend.task_map <= TASK1_ALL & axis_mask(MAX_AXES); // R07
      end
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign awready = !q.aw_got;
  assign wready = !q.w_got;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign dig_out = q.dig_out;
  assign unit_active = q.unit_act;
  assign act_params = '{ref_ofs: a_ref, wrk_ofs: a_wrk, feed: a_feed,
                         accel: a_acc, decel: a_dec};
  assign pass_time = q.pass_time;
  assign follow_count = q.follow;
  assign misc_cfg = q.misc;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  unit_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.boot |=> $stable(q.unit_act)) // R01
    else $error("unit values changed without power-on");
  ref_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !events.origin_done |=> $stable(a_ref)) // R03
    else $error("reference offset changed early");
  wrk_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !events.origin_set |=> $stable(a_wrk)) // R04
    else $error("workpiece offset changed early");
  feed_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !op_evt |=> $stable(a_feed) && $stable(a_acc)) // R05
    else $error("feed values changed early");
  axes_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.unit_pend.axes != 3'h0 && q.unit_pend.axes <= MAX_AXES) // R06
    else $error("axis count out of range");
  hw_ratio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.unit_act.enc_sel |=> follow_count == {2'b00,
      $past(handwheel_pulse_input)}) // R12
    else $error("handwheel ratio not one");
  pass_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    op_evt |=> pass_time == ($past(q.unit_act.pass_decel) ? $past(a_dec)
      : $past(a_acc))) // R14
    else $error("pass time source wrong");
  brake_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.unit_act.axes == 3'h4 && q.unit_act.out_general == 4'h0
      |=> dig_out == $past(brake_req)) // R09
    else $error("brake outputs not following axes");

endmodule : motion_param_commit

// File: tb/axi_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host tool issuing AXI4-Lite parameter transfers
// ---------------------------------------------------------------
module axi_host_model (
  input wire logic ref_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h00;
    arvalid = 1'h0;
    rready = 1'h0;
  end

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (!aw_done && awready) begin
        awvalid <= 1'h0;
        aw_done = 1'h1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'h0;
        w_done = 1'h1;
      end
    end
    while (!bvalid) @(posedge ref_clk);
    bready <= 1'h0;
  endtask : write

  task automatic read(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge ref_clk);
    rready <= 1'h0;
  endtask : read
endmodule : axi_host_model

// File: tb/tb_motion_param_commit.sv
`timescale 1ns/1ps
module tb_motion_param_commit;
  import motion_param_pkg::*;
  logic ref_clk, rst_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, pass_time, misc_cfg;
  logic [3:0] wstrb, brake_req, gp_out, dig_out;
  logic [1:0] bresp, rresp, exp_b;
  event_s events;
  logic [15:0] handwheel_pulse_input, enc_count;
  unit_cfg_s unit_active;
  param_set_s act_params;
  logic [17:0] follow_count;
  int fail_count, total_checks;
  integer seed;
  logic [33:0] rq[$];
  logic [33:0] exp_r;
  logic [1:0] bq[$];
  logic [31:0] r1, r2, r3;

  motion_param_commit #(.MAX_AXES(3'h4)) dut_u (.*);
  axi_host_model host_u (.*);

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] resp);
    bq.push_back(resp);
    host_u.write(a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] resp);
    rq.push_back({resp, d});
    host_u.read(a);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    settle(3);
  endtask : do_reset

  task automatic pulse(input event_s e);
    @(posedge ref_clk);
    events <= e;
    @(posedge ref_clk);
    events <= '{auto_mode: e.auto_mode, default: 1'h0};
    settle(3);
  endtask : pulse

  // ---------------------------------------------------------------
  // Response monitor
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rvalid === 1'h1 && rready === 1'h1) begin
      exp_r = rq.pop_front();
      check(rdata, exp_r[31:0]);
      check(32'(rresp), 32'(exp_r[33:32]));
    end
    if (bvalid === 1'h1 && bready === 1'h1) begin
      exp_b = bq.pop_front();
      check(32'(bresp), 32'(exp_b));
    end
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 88184;
    rst_n = 1'h0;
    events = '0;
    handwheel_pulse_input = 16'h0000;
    enc_count = 16'h0000;
    brake_req = 4'h0;
    gp_out = 4'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    settle(3);
    check(32'(unit_active.axes), 32'h0000_0004);
    check(32'(unit_active.task_map), 32'(TASK1_ALL));
    check(32'(unit_active.out_general), 32'(OUT_BRAKE_ALL));
    check(32'(unit_active.enc_sel), 32'h0000_0000);
    brake_req <= 4'($random(seed));
    handwheel_pulse_input <= 16'($random(seed));
    settle(1);
    gp_out <= ~brake_req;
    settle(3);
    check(32'(dig_out), 32'(brake_req));
    check(32'(follow_count), 32'(handwheel_pulse_input));
    r1 = $random(seed);
    r2 = $random(seed);
    r3 = $random(seed);
    wr(ADDR_ACCEL, r1, RESP_OKAY);
    wr(ADDR_DECEL, r2, RESP_OKAY);
    wr(ADDR_FEED, r3, RESP_OKAY);
    settle(2);
    check(act_params.feed, 32'h0000_0000);
    pulse('{motion_code: 1'h1, auto_mode: 1'h1, default: 1'h0});
    check(act_params.feed, r3);
    check(act_params.decel, r2);
    rd(ADDR_ACT_FEED, r3, RESP_OKAY);
    wr(ADDR_ACCEL, ~r1, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0008, RESP_OKAY);
    pulse('{op_cmd: 1'h1, default: 1'h0});
    check(pass_time, r1);
    check(act_params.accel, ~r1);
    wr(ADDR_REF_OFS, r3, RESP_OKAY);
    pulse('{origin_set: 1'h1, default: 1'h0});
    check(act_params.ref_ofs, 32'h0000_0000);
    rd(ADDR_REF_OFS, r3, RESP_OKAY);
    pulse('{origin_done: 1'h1, default: 1'h0});
    check(act_params.ref_ofs, r3);
    rd(ADDR_ACT_REF, r3, RESP_OKAY);
    wr(ADDR_WRK_OFS, r2, RESP_OKAY);
    pulse('{origin_done: 1'h1, default: 1'h0});
    check(act_params.wrk_ofs, 32'h0000_0000);
    pulse('{origin_set: 1'h1, default: 1'h0});
    check(act_params.wrk_ofs, r2);
    rd(ADDR_ACT_WRK, r2, RESP_OKAY);
    wr(ADDR_MISC, r1, RESP_OKAY);
    settle(1);
    check(misc_cfg, r1);
    wr(ADDR_HW_RATIO, r2, RESP_OKAY);
    rd(ADDR_HW_RATIO, r2, RESP_OKAY);
    wr(8'h3c, r1, RESP_SLVERR);
    rd(8'h3c, 32'h0000_0000, RESP_SLVERR);
    wr(ADDR_TASK_CFG, 32'h0000_0021, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_UNIT_CFG, 32'h0000_0912 | (32'(i) << 9), RESP_OKAY);
      rd(ADDR_UNIT_CFG, 32'h0000_0912 | (32'(i) << 9), RESP_OKAY);
      settle(2);
      check(32'(unit_active.axes), (i == 0) ? 32'h4 : 32'h2);
      do_reset();
      check(32'(unit_active.axes), 32'h0000_0002);
      check(32'(unit_active.task_map), 32'h0000_0021);
      check(32'(unit_active.enc_sel), 32'h0000_0001);
      enc_count <= 16'($random(seed));
      brake_req <= 4'($random(seed));
      gp_out <= 4'($random(seed));
      settle(3);
      check(32'(follow_count), 32'(enc_count) << i);
      check(32'(dig_out), {30'h0, brake_req[1], gp_out[0]});
    end
    r3 = $random(seed);
    wr(ADDR_DECEL, r3, RESP_OKAY);
    pulse('{op_cmd: 1'h1, default: 1'h0});
    pulse('{op_cmd: 1'h1, default: 1'h0});
    check(pass_time, r3);
    rd(ADDR_ACT_PASS, r3, RESP_OKAY);
    settle(2);
    check(32'(rq.size() + bq.size()), 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_motion_param_commit
